// ### sbc_ctrl.sv
// sensorless three-phase commutation controller with axi4-lite registers
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "sbc_map.svh"
// Functional notes
// - over-temperature indication turns every phase output off, non-driving.
// - leave over-temperature once the low-threshold indication shows, resume driving.
// - direction high steps phases U,V,W; low steps U,W,V.
// - a floating direction input reads as low.
// - drive is on while the speed input is high, off while low.
// - a floating speed input reads as high, full speed.
// - speed input low lets motor coast; once stopped, enter power saving.
// - ramp current between outgoing and incoming phase at each commutation.
// - current-sense trip cuts the drive until the next speed pulse.
// - startup oscillator ticks set the commutation rate during startup.
// - in run, each position comparator edge times the next commutation.
// - tach output toggles with commutation like a hall sensor signal.
// - internal counter times lock drive-on and drive-off intervals.
// - drive-on interval without rotation lasts two seconds.
// - drive-off interval after a failed attempt lasts four seconds.

module sbc_ctrl import sbc_pkg::*; #(
  parameter int LOCK_ON_CYC = `SBC_LOCK_ON_CYC,
  parameter int LOCK_OFF_CYC = `SBC_LOCK_OFF_CYC,
  parameter int STOP_CYC = `SBC_STOP_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`SBC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SBC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pwm_in,
  input wire logic pwm_in_floating,
  input wire logic dir_in,
  input wire logic dir_in_floating,
  input wire logic osc_in,
  input wire logic position_comparator_in,
  input wire logic thermal_over_hi,
  input wire logic thermal_below_lo,
  input wire logic current_limit_trip,
  output logic phase_a_drive_hi,
  output logic phase_a_drive_lo,
  output logic phase_b_drive_hi,
  output logic phase_b_drive_lo,
  output logic phase_c_drive_hi,
  output logic phase_c_drive_lo,
  input wire logic tach_pulse_out_in,
  output logic tach_pulse_out_out,
  output logic tach_pulse_out_oe,
  output logic irq
);

  // ----------------------------------------------------------------------
  // timer sizing
  // ----------------------------------------------------------------------
  localparam int TMAX0 = (LOCK_OFF_CYC > LOCK_ON_CYC) ? LOCK_OFF_CYC : LOCK_ON_CYC;
  localparam int TMAX = (STOP_CYC > TMAX0) ? STOP_CYC : TMAX0;
  localparam int TW = $clog2(TMAX + 1);
  localparam logic [TW-1:0] ON_LAST = TW'(LOCK_ON_CYC - 1);
  localparam logic [TW-1:0] OFF_LAST = TW'(LOCK_OFF_CYC - 1);
  localparam logic [TW-1:0] STOP_LAST = TW'(STOP_CYC - 1);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  sbc_state_t st_q;
  sbc_state_t st_d;
  sbc_step_t step_q;
  sbc_step_t prev_q;
  sbc_step_t step_nx;
  logic [TW-1:0] tmr_q;
  logic [2:0] edges_q;
  logic osc_q;
  logic cmp_q;
  logic pwm_q;
  logic cl_q;
  logic tach_low_q;
  logic [2:0] hi_q;
  logic [2:0] lo_q;
  logic [2:0] hi_d;
  logic [2:0] lo_d;
  logic [31:0] ctrl_q;
  logic [`SBC_IRQ_W-1:0] irq_stat_q;
  logic [`SBC_IRQ_W-1:0] irq_mask_q;
  logic [`SBC_IRQ_W-1:0] ev;
  logic [31:0] comm_cnt_q;
  logic aw_full_q;
  logic w_full_q;
  logic [`SBC_AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic pwm_eff;
  logic dir_eff;
  logic osc_rise;
  logic cmp_edge;
  logic pwm_rise;
  logic comm;
  logic driving;
  logic active;
  logic rise;
  logic fall;
  logic st_chg;
  logic tmr_clr;
  logic wr_fire;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [31:0] stat_word;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;
  logic [5:0] wa;
  logic [5:0] ra;

  // ----------------------------------------------------------------------
  // commutation table
  // ----------------------------------------------------------------------
  function automatic logic [1:0] hi_of(input sbc_step_t s);
    case (s)
      3'h0, 3'h1: hi_of = 2'h0;
      3'h2, 3'h3: hi_of = 2'h1;
      default: hi_of = 2'h2;
    endcase
  endfunction : hi_of

  function automatic logic [1:0] lo_of(input sbc_step_t s);
    case (s)
      3'h0: lo_of = 2'h1;
      3'h1, 3'h2: lo_of = 2'h2;
      3'h3, 3'h4: lo_of = 2'h0;
      default: lo_of = 2'h1;
    endcase
  endfunction : lo_of

  // ----------------------------------------------------------------------
  // pin conditioning
  // ----------------------------------------------------------------------
  assign pwm_eff = pwm_in_floating | pwm_in;
  assign dir_eff = ~dir_in_floating & dir_in;
  assign osc_rise = osc_in & ~osc_q;
  assign cmp_edge = position_comparator_in ^ cmp_q;
  assign pwm_rise = pwm_eff & ~pwm_q;

  // ----------------------------------------------------------------------
  // commutation step
  // ----------------------------------------------------------------------
  // direction is followed live; the host keeps it still while spinning
  assign step_nx = dir_eff ?
    ((step_q == `SBC_LAST_STEP) ? 3'h0 : 3'(step_q + 3'h1)) :
    ((step_q == 3'h0) ? `SBC_LAST_STEP : 3'(step_q - 3'h1));
  assign comm = ((st_q == SBC_ST_START) & osc_rise) |
    ((st_q == SBC_ST_RUN) & cmp_edge);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_q <= 3'h0;
      prev_q <= 3'h0;
      tach_low_q <= 1'b0;
      comm_cnt_q <= 32'h0;
    end else if (comm) begin
      prev_q <= step_q;
      step_q <= step_nx;
      tach_low_q <= (step_nx >= `SBC_HALF_STEP);
      comm_cnt_q <= comm_cnt_q + 32'h1;
    end
  end

  sbc_soft_ramp #(
    .W(8)
  ) u_ramp (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(comm),
    .step(ctrl_q[`SBC_CTRL_STEP_MSB:`SBC_CTRL_STEP_LSB]),
    .rise(rise),
    .fall(fall)
  );

  // ----------------------------------------------------------------------
  // phase drive
  // ----------------------------------------------------------------------
  assign driving = (st_q == SBC_ST_START) | (st_q == SBC_ST_RUN);
  assign active = driving & ctrl_q[`SBC_CTRL_EN_BIT] & pwm_eff &
    ~cl_q & ~current_limit_trip;

  // incoming phase ramps up while the outgoing one ramps down
  for (genvar p = 0; p < 3; p++) begin : g_phase
    assign hi_d[p] = active & ((hi_of(step_q) == 2'(p)) ? rise :
      ((hi_of(prev_q) == 2'(p)) & fall));
    assign lo_d[p] = active & ((lo_of(step_q) == 2'(p)) ? rise :
      ((lo_of(prev_q) == 2'(p)) & fall));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_q <= 3'h0;
      lo_q <= 3'h0;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end

  assign phase_a_drive_hi = hi_q[0];
  assign phase_a_drive_lo = lo_q[0];
  assign phase_b_drive_hi = hi_q[1];
  assign phase_b_drive_lo = lo_q[1];
  assign phase_c_drive_hi = hi_q[2];
  assign phase_c_drive_lo = lo_q[2];
  assign tach_pulse_out_out = 1'b0;
  assign tach_pulse_out_oe = tach_low_q;

  // ----------------------------------------------------------------------
  // input history and current limit latch
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_q <= 1'b0;
      cmp_q <= 1'b0;
      pwm_q <= 1'b0;
      cl_q <= 1'b0;
    end else begin
      osc_q <= osc_in;
      cmp_q <= position_comparator_in;
      pwm_q <= pwm_eff;
      // trip wins over the release at a new speed pulse
      cl_q <= current_limit_trip | (cl_q & ~pwm_rise);
    end
  end

  // ----------------------------------------------------------------------
  // motor state machine
  // ----------------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    if (thermal_over_hi) begin
      st_d = SBC_ST_OTP;
    end else begin
      case (st_q)
        SBC_ST_SAVE: begin
          if (pwm_eff) begin
            st_d = SBC_ST_START;
          end
        end
        SBC_ST_START: begin
          if (edges_q == `SBC_START_EDGES) begin
            st_d = SBC_ST_RUN;
          end else if (!pwm_eff && tmr_q >= STOP_LAST) begin
            st_d = SBC_ST_SAVE;
          end else if (tmr_q >= ON_LAST) begin
            st_d = SBC_ST_LOCK;
          end
        end
        SBC_ST_RUN: begin
          if (!pwm_eff) begin
            if (tmr_q >= STOP_LAST) begin
              st_d = SBC_ST_SAVE;
            end
          end else if (tmr_q >= ON_LAST) begin
            st_d = SBC_ST_LOCK;
          end
        end
        SBC_ST_LOCK: begin
          if (tmr_q >= OFF_LAST) begin
            st_d = pwm_eff ? SBC_ST_START : SBC_ST_SAVE;
          end
        end
        SBC_ST_OTP: begin
          if (thermal_below_lo) begin
            st_d = pwm_eff ? SBC_ST_START : SBC_ST_SAVE;
          end
        end
        default: begin
          st_d = SBC_ST_SAVE;
        end
      endcase
    end
  end

  assign st_chg = (st_d != st_q);
  // in run the timer measures the gap between edges, elsewhere time in state
  assign tmr_clr = st_chg | ((st_q == SBC_ST_RUN) & cmp_edge);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= SBC_ST_SAVE;
      tmr_q <= '0;
      edges_q <= 3'h0;
    end else begin
      st_q <= st_d;
      if (tmr_clr) begin
        tmr_q <= '0;
      end else if (!(&tmr_q)) begin
        tmr_q <= tmr_q + TW'(1);
      end
      if (st_chg) begin
        edges_q <= 3'h0;
      end else if (cmp_edge && edges_q != `SBC_START_EDGES) begin
        edges_q <= edges_q + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------------
  assign ev[`SBC_IRQ_OTP_ON] = st_chg & (st_d == SBC_ST_OTP);
  assign ev[`SBC_IRQ_OTP_OFF] = st_chg & (st_q == SBC_ST_OTP);
  assign ev[`SBC_IRQ_LOCK] = st_chg & (st_d == SBC_ST_LOCK);
  assign ev[`SBC_IRQ_ILIM] = current_limit_trip & driving;
  assign ev[`SBC_IRQ_SAVE] = st_chg & (st_d == SBC_ST_SAVE);
  assign ev[`SBC_IRQ_RUN] = st_chg & (st_d == SBC_ST_RUN);
  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------------
  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready = ~w_full_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  assign wa = awaddr_q[7:2];
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign wbits = wdata_q & wmask;
  assign wr_hit = (wa == `SBC_CTRL_OFS >> 2) | (wa == `SBC_STAT_OFS >> 2) |
    (wa == `SBC_IRQ_STAT_OFS >> 2) | (wa == `SBC_IRQ_MASK_OFS >> 2) |
    (wa == `SBC_COMM_CNT_OFS >> 2);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `SBC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_q) begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_full_q) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `SBC_RESP_OKAY : `SBC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `SBC_CTRL_RST;
      irq_mask_q <= '0;
      irq_stat_q <= '0;
    end else begin
      if (wr_fire && wa == (`SBC_CTRL_OFS >> 2)) begin
        ctrl_q <= ((ctrl_q & ~wmask) | wbits) & `SBC_CTRL_MASK;
      end
      if (wr_fire && wa == (`SBC_IRQ_MASK_OFS >> 2)) begin
        irq_mask_q <= (irq_mask_q & ~wmask[`SBC_IRQ_W-1:0]) | wbits[`SBC_IRQ_W-1:0];
      end
      // a new event outranks a clear in the same cycle
      if (wr_fire && wa == (`SBC_IRQ_STAT_OFS >> 2)) begin
        irq_stat_q <= (irq_stat_q & ~wbits[`SBC_IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------------
  assign ra = s_axi_araddr[7:2];
  assign stat_word = {21'h0, step_q, 2'h0, tach_pulse_out_in, pwm_eff, dir_eff, st_q};
  assign rd_hit = (ra == `SBC_CTRL_OFS >> 2) | (ra == `SBC_STAT_OFS >> 2) |
    (ra == `SBC_IRQ_STAT_OFS >> 2) | (ra == `SBC_IRQ_MASK_OFS >> 2) |
    (ra == `SBC_COMM_CNT_OFS >> 2);
  assign rd_word =
    (ra == `SBC_CTRL_OFS >> 2) ? ctrl_q :
    (ra == `SBC_STAT_OFS >> 2) ? stat_word :
    (ra == `SBC_IRQ_STAT_OFS >> 2) ? 32'(irq_stat_q) :
    (ra == `SBC_IRQ_MASK_OFS >> 2) ? 32'(irq_mask_q) :
    (ra == `SBC_COMM_CNT_OFS >> 2) ? comm_cnt_q : 32'h0;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `SBC_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? `SBC_RESP_OKAY : `SBC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : sbc_ctrl

// ### sbc_ctrl_assertions.sv
// assertion checker bound to the commutation controller ports
`timescale 1ns/1ps

module sbc_ctrl_chk #(
  parameter int LOCK_ON_CYC = 200
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pwm_in,
  input wire logic pwm_in_floating,
  input wire logic thermal_over_hi,
  input wire logic current_limit_trip,
  input wire logic position_comparator_in,
  input wire logic phase_a_drive_hi,
  input wire logic phase_a_drive_lo,
  input wire logic phase_b_drive_hi,
  input wire logic phase_b_drive_lo,
  input wire logic phase_c_drive_hi,
  input wire logic phase_c_drive_lo,
  input wire logic tach_pulse_out_out,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  wire drv_on = phase_a_drive_hi | phase_a_drive_lo | phase_b_drive_hi | phase_b_drive_lo |
    phase_c_drive_hi | phase_c_drive_lo;
  wire pwm_seen = pwm_in | pwm_in_floating;
  logic cmp_q;
  int sil_q;
  // driven cycles without a rotor edge; a blocked rotor must not be pushed for long
  always_ff @(posedge aclk) begin
    cmp_q <= position_comparator_in;
    sil_q <= (!aresetn || !drv_on || cmp_q != position_comparator_in) ? 0 : sil_q + 1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_otp_outputs_open: assert property (thermal_over_hi [*3] |-> !drv_on)
    else $error("phase driven while over temperature");
  a_pwm_gates_drive: assert property (!pwm_seen [*3] |-> !drv_on)
    else $error("phase driven while speed input low");
  a_trip_cuts_drive: assert property (current_limit_trip [*3] |-> !drv_on)
    else $error("phase driven while current trip high");
  a_no_shoot_through: assert property (!(phase_a_drive_hi && phase_a_drive_lo) &&
    !(phase_b_drive_hi && phase_b_drive_lo) && !(phase_c_drive_hi && phase_c_drive_lo))
    else $error("both switches of one phase on");
  a_lock_on_bound: assert property (sil_q <= LOCK_ON_CYC + 4)
    else $error("drive held on without rotation too long");
  a_tach_open_drain: assert property (!tach_pulse_out_out)
    else $error("tach output drives high");
  a_read_one_cycle: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
endmodule : sbc_ctrl_chk

bind sbc_ctrl sbc_ctrl_chk #(.LOCK_ON_CYC(LOCK_ON_CYC)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .pwm_in(pwm_in), .pwm_in_floating(pwm_in_floating),
  .thermal_over_hi(thermal_over_hi), .current_limit_trip(current_limit_trip),
  .position_comparator_in(position_comparator_in),
  .phase_a_drive_hi(phase_a_drive_hi), .phase_a_drive_lo(phase_a_drive_lo),
  .phase_b_drive_hi(phase_b_drive_hi), .phase_b_drive_lo(phase_b_drive_lo),
  .phase_c_drive_hi(phase_c_drive_hi), .phase_c_drive_lo(phase_c_drive_lo),
  .tach_pulse_out_out(tach_pulse_out_out), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp)
);

// ### sbc_map.svh
// register offsets, field positions, reset values and timing counts of the commutation block
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define SBC_CLK_HZ 20000000
`define SBC_LOCK_ON_MS 2000
`define SBC_LOCK_OFF_MS 4000
`define SBC_STOP_MS 100
`define SBC_LOCK_ON_CYC (`SBC_LOCK_ON_MS * (`SBC_CLK_HZ / 1000))
`define SBC_LOCK_OFF_CYC (`SBC_LOCK_OFF_MS * (`SBC_CLK_HZ / 1000))
`define SBC_STOP_CYC (`SBC_STOP_MS * (`SBC_CLK_HZ / 1000))
`define SBC_START_EDGES 3'h6
`define SBC_LAST_STEP 3'h5
`define SBC_HALF_STEP 3'h3

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define SBC_AW 8
`define SBC_CTRL_OFS 8'h00
`define SBC_STAT_OFS 8'h04
`define SBC_IRQ_STAT_OFS 8'h08
`define SBC_IRQ_MASK_OFS 8'h0c
`define SBC_COMM_CNT_OFS 8'h10
`define SBC_CTRL_EN_BIT 0
`define SBC_CTRL_STEP_LSB 4
`define SBC_CTRL_STEP_MSB 11
`define SBC_CTRL_MASK 32'h00000ff1
`define SBC_CTRL_RST 32'h00000101
`define SBC_RESP_OKAY 2'h0
`define SBC_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------------
`define SBC_IRQ_W 6
`define SBC_IRQ_OTP_ON 0
`define SBC_IRQ_OTP_OFF 1
`define SBC_IRQ_LOCK 2
`define SBC_IRQ_ILIM 3
`define SBC_IRQ_SAVE 4
`define SBC_IRQ_RUN 5

`endif

// ### sbc_motor.sv
// motor winding model: back-emf comparator edges while driven, tach pull-up
`timescale 1ns/1ps

module sbc_motor #(
  parameter int PERIOD = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stall,
  input wire logic drv_on,
  input wire logic tach_oe,
  output logic cmp_out,
  output logic tach_pin
);
  int cnt_q;
  wire turn = !stall && drv_on;
  // rotor only turns while energised; a stalled rotor gives no edges at all
  always_ff @(posedge aclk) begin
    cnt_q <= (!turn || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
    cmp_out <= !aresetn ? 1'h0 : cmp_out ^ (turn && cnt_q == PERIOD - 1);
  end
  assign tach_pin = tach_oe ? 1'h0 : 1'h1;
endmodule : sbc_motor

// ### sbc_pkg.sv
// types of the commutation block
package sbc_pkg;

  typedef enum logic [2:0] {
    SBC_ST_SAVE  = 3'b000,
    SBC_ST_START = 3'b001,
    SBC_ST_RUN   = 3'b010,
    SBC_ST_LOCK  = 3'b011,
    SBC_ST_OTP   = 3'b100
  } sbc_state_t;

  typedef logic [2:0] sbc_step_t;

endpackage : sbc_pkg

// ### sbc_soft_ramp.sv
// variable-duty ramp that hands current from the old phase to the new one
`timescale 1ns/1ps

module sbc_soft_ramp #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic restart,
  input wire logic [W-1:0] step,
  output logic rise,
  output logic fall
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] lvl_q;
  logic [W-1:0] stp;
  logic [W:0] sum;
  logic [W-1:0] lvl_nx;
  logic full;

  // a zero step would freeze the handover at its start, old phase fully on
  assign stp = (step == '0) ? W'(1) : step;
  assign sum = {1'b0, lvl_q} + {1'b0, stp};
  assign lvl_nx = sum[W] ? '1 : sum[W-1:0];
  assign full = &lvl_q;
  assign rise = full | (cnt_q < lvl_q);
  assign fall = ~rise;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
      lvl_q <= '1;
    end else begin
      cnt_q <= cnt_q + W'(1);
      if (restart) begin
        lvl_q <= '0;
      end else if ((&cnt_q) && !full) begin
        lvl_q <= lvl_nx;
      end
    end
  end

endmodule : sbc_soft_ramp

// ### tb.sv
// self-checking bench for the commutation controller
`timescale 1ns/1ps
`include "sbc_map.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; \
  $display("Error at %0t got %h exp %h", $time, (a), (e)); end end

module tb import sbc_pkg::*;;
  logic aclk = 1'h0, aresetn = 1'h0, stall = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic pwm_in = 1'h0, pwm_fl = 1'h0, dir_in = 1'h1, dir_fl = 1'h0, osc_in = 1'h0;
  logic t_hi = 1'h0, t_lo = 1'h1, trip = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, ah, al, bh, bl, ch, cl;
  logic tach_oe, cmp, tach_pin;
  logic [1:0] bresp, rresp, lresp;
  logic [2:0] s0, ex;
  logic [2:0] cfg [3] = '{3'h4, 3'h1, 3'h6};
  int err_count = 0, compares = 0, cyc_n = 0, n, k;
  wire drv_on = ah | al | bh | bl | ch | cl;

  sbc_ctrl #(.LOCK_ON_CYC(600), .LOCK_OFF_CYC(800), .STOP_CYC(100)) uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pwm_in(pwm_in), .pwm_in_floating(pwm_fl), .dir_in(dir_in), .dir_in_floating(dir_fl),
    .osc_in(osc_in), .position_comparator_in(cmp), .thermal_over_hi(t_hi),
    .thermal_below_lo(t_lo), .current_limit_trip(trip), .phase_a_drive_hi(ah),
    .phase_a_drive_lo(al), .phase_b_drive_hi(bh), .phase_b_drive_lo(bl),
    .phase_c_drive_hi(ch), .phase_c_drive_lo(cl), .tach_pulse_out_in(tach_pin),
    .tach_pulse_out_out(), .tach_pulse_out_oe(tach_oe), .irq(irq));
  sbc_motor #(.PERIOD(20)) u_motor (.aclk(aclk), .aresetn(aresetn), .stall(stall),
    .drv_on(drv_on), .tach_oe(tach_oe), .cmp_out(cmp), .tach_pin(tach_pin));

  always #25 aclk = ~aclk;
  always begin
    repeat (10) @(posedge aclk);
    osc_in <= ~osc_in;
  end
  always @(posedge aclk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_count++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // bus and timing tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int c);
    repeat (c) @(posedge aclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'h1; wvalid <= 1'h1;
    // bready comes late so the response has to hold for a cycle
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'h1;
    end
    lresp = bresp;
    bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    v = rdata;
    lresp = rresp;
    rready <= 1'h0;
  endtask : rd
  task automatic wait_st(input logic [2:0] s);
    // a full lock off interval plus a restart must fit in the poll
    for (int i = 0; i < 400; i++) begin
      rd(`SBC_STAT_OFS, d);
      if (d[2:0] === s) break;
    end
    `CHK(d[2:0], s)
  endtask : wait_st
  task automatic wait_drv(input logic lvl, input int lim);
    for (int i = 0; i < lim && drv_on !== lvl; i++) @(posedge aclk);
  endtask : wait_drv
  task automatic run_len(input logic lvl, output int c);
    c = 0;
    while (drv_on === lvl && c < 3000) begin
      @(posedge aclk);
      c++;
    end
  endtask : run_len
  task end_sim;
    $display("TB: %0d compares, %0d errors", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    cyc(16);
    aresetn <= 1'h1;
    `CHK({drv_on, tach_oe, irq}, 3'h0)
    rd(`SBC_CTRL_OFS, d);
    `CHK(d, `SBC_CTRL_RST)
    rd(8'h40, d);
    `CHK({lresp, d}, {`SBC_RESP_SLVERR, 32'h0})
    wr(8'h44, 32'h1);
    `CHK(lresp, `SBC_RESP_SLVERR)
    wr(`SBC_IRQ_MASK_OFS, 32'h4);
    rd(`SBC_IRQ_MASK_OFS, d);
    `CHK({lresp, d}, {`SBC_RESP_OKAY, 32'h4})
    $display("test registers done");
    for (k = 0; k < 3; k++) begin
      pwm_in <= 1'h0; pwm_fl <= 1'h0; stall <= 1'h0;
      wait_st(SBC_ST_SAVE);
      dir_in <= cfg[k][2]; dir_fl <= cfg[k][1];
      pwm_in <= !cfg[k][0]; pwm_fl <= cfg[k][0]; stall <= 1'h1;
      wait_st(SBC_ST_START);
      rd(`SBC_COMM_CNT_OFS, d);
      n = d;
      cyc(60);
      rd(`SBC_COMM_CNT_OFS, d);
      `CHK(d > n, 1'h1)
      stall <= 1'h0;
      wait_st(SBC_ST_RUN);
      stall <= 1'h1;
      cyc(4);
      rd(`SBC_STAT_OFS, d);
      s0 = d[10:8];
      stall <= 1'h0;
      cyc(24);
      stall <= 1'h1;
      cyc(4);
      rd(`SBC_STAT_OFS, d);
      ex = (cfg[k] == 3'h4) ? ((s0 == 3'h5) ? 3'h0 : s0 + 3'h1) : ((s0 == 3'h0) ? 3'h5 : s0 - 3'h1);
      `CHK(d[10:8], ex)
      `CHK(tach_pin, ex < 3'h3)
    end
    stall <= 1'h0;
    $display("test direction done");
    trip <= 1'h1;
    cyc(4);
    `CHK(drv_on, 1'h0)
    trip <= 1'h0;
    cyc(10);
    `CHK(drv_on, 1'h0)
    pwm_in <= 1'h0;
    cyc(1);
    pwm_in <= 1'h1;
    wait_drv(1'h1, 20);
    `CHK(drv_on, 1'h1)
    $display("test current limit done");
    t_lo <= 1'h0; t_hi <= 1'h1;
    cyc(4);
    `CHK(drv_on, 1'h0)
    wait_st(SBC_ST_OTP);
    t_hi <= 1'h0;
    cyc(10);
    `CHK(drv_on, 1'h0)
    t_lo <= 1'h1;
    wait_drv(1'h1, 100);
    `CHK(drv_on, 1'h1)
    wait_st(SBC_ST_RUN);
    $display("test thermal done");
    stall <= 1'h1;
    wait_drv(1'h0, 700);
    run_len(1'h0, n);
    `CHK(n >= 792 && n <= 808, 1'h1)
    run_len(1'h1, n);
    `CHK(n >= 592 && n <= 608, 1'h1)
    stall <= 1'h0;
    wait_st(SBC_ST_RUN);
    rd(`SBC_IRQ_STAT_OFS, d);
    `CHK({d[`SBC_IRQ_LOCK], irq}, 2'h3)
    wr(`SBC_IRQ_STAT_OFS, 32'h4);
    rd(`SBC_IRQ_STAT_OFS, d);
    `CHK({d[`SBC_IRQ_LOCK], irq}, 2'h0)
    $display("test lock done");
    end_sim();
  end
endmodule : tb
